// ==== hdl/fdc_fifo_mem.sv ====
// storage array of the data fifo, one write port and one registered read port
// assumes the caller keeps the pointers in range; read-during-write returns the old word
`timescale 1ns/1ps
module fdc_fifo_mem #(
  parameter int W     = 8,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic          core_clk_i,
  input  wire logic          nrst_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [W-1:0]  wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [W-1:0]  rdata_o
);

  logic [W-1:0] mem_r [DEPTH];

  // array itself carries no reset, only the read register does
  always_ff @(posedge core_clk_i)
  begin
    if (we_i)
    begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rdata_o <= '0;
    end
    else
    begin
      rdata_o <= mem_r[raddr_i];
    end
  end

endmodule : fdc_fifo_mem

// ==== hdl/fdc_host_port.sv ====
// host side parallel port: strobed register access, dma handshake, data fifo
// assumes host pins arrive asynchronously and the controller core sits on core_clk_i
`timescale 1ns/1ps
module floppy_host_bus_port
  import fdc_port_pkg::*;
#(
  parameter int FIFO_DEPTH_P = fdc_port_pkg::FIFO_DEPTH
) (
  input  wire logic                              core_clk_i,
  input  wire logic                              nrst_i,
  input  wire logic [fdc_port_pkg::DATA_W-1:0]   host_data_bus_i,
  output logic      [fdc_port_pkg::DATA_W-1:0]   host_data_bus_o,
  output logic                                   host_data_bus_oe_o,
  input  wire logic                              host_read_strobe_n_i,
  input  wire logic                              host_write_strobe_n_i,
  input  wire logic [fdc_port_pkg::SEL_W-1:0]    register_select_i,
  input  wire logic                              chip_select_n_i,
  input  wire logic                              dma_grant_n_i,
  input  wire logic                              terminal_count_i,
  input  wire logic                              reset_i,
  output logic                                   dma_request_o,
  output logic                                   irq_o,
  input  wire logic                              irq_pending_i,
  input  wire logic                              to_host_i,
  input  wire logic                              xfer_active_i,
  input  wire logic                              dma_enable_i,
  input  wire logic                              non_burst_i,
  input  wire logic                              last_byte_i,
  input  wire logic                              disk_in_valid_i,
  input  wire logic [fdc_port_pkg::DATA_W-1:0]   disk_in_data_i,
  input  wire logic                              disk_out_req_i,
  output logic      [fdc_port_pkg::DATA_W-1:0]   disk_out_data_o,
  output logic                                   disk_out_valid_o,
  input  wire logic                              flag_clr_i,
  output logic                                   overrun_o,
  output logic                                   underrun_o,
  output logic                                   tc_seen_o,
  output logic                                   chip_reset_o,
  input  wire logic [fdc_port_pkg::DATA_W-1:0]   reg_rd_data_i,
  output logic      [fdc_port_pkg::SEL_W-1:0]    reg_sel_o,
  output logic                                   reg_wr_o,
  output logic      [fdc_port_pkg::DATA_W-1:0]   reg_wr_data_o
);
  import fdc_port_pkg::*;

  localparam int AW = $clog2(FIFO_DEPTH_P);
  localparam int CW = AW + 1;
  localparam logic [RST_CNT_W-1:0] RST_LIM = RST_CNT_W'(RESET_MIN_CYC);

  if (FIFO_DEPTH_P < 2 || (1 << AW) != FIFO_DEPTH_P)
  begin : g_depth_check
    $error("fifo depth must be a power of two, at least 2");
  end
  if (RESET_MIN_CYC >= (1 << RST_CNT_W))
  begin : g_rst_check
    $error("reset counter too narrow");
  end

  // a cycle touches the fifo when granted, or when addressed at the data register
  function automatic logic hits_data(input logic dma, input logic [SEL_W-1:0] sel);
    hits_data = dma || (sel == DATA_REG_SEL);
  endfunction : hits_data

  // two-stage synchroniser on every pin, plus one more stage for edge detection
  logic [PIN_W-1:0] meta_r;
  logic [PIN_W-1:0] pins_r;
  logic [PIN_W-1:0] prev_r;
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      meta_r <= {2'b00, 5'h1f, 10'h000};
      pins_r <= {2'b00, 5'h1f, 10'h000};
      prev_r <= {2'b00, 5'h1f, 10'h000};
    end
    else
    begin
      meta_r <= {reset_i, terminal_count_i, dma_grant_n_i, chip_select_n_i,
                 host_write_strobe_n_i, host_read_strobe_n_i, register_select_i,
                 host_data_bus_i};
      pins_r <= meta_r;
      prev_r <= pins_r;
    end
  end

  logic [DATA_W-1:0] pin_data;
  logic [SEL_W-1:0]  pin_sel;
  logic              rd_fall;
  logic              wr_fall;
  logic              dack_fall;
  logic              dma_on;
  logic              sel_any;
  assign pin_data  = pins_r[PIN_DATA_LSB +: DATA_W];
  assign pin_sel   = pins_r[PIN_SEL_LSB +: SEL_W];
  assign rd_fall   = prev_r[PIN_RD] && !pins_r[PIN_RD];
  assign wr_fall   = prev_r[PIN_WR] && !pins_r[PIN_WR];
  assign dack_fall = prev_r[PIN_DACK] && !pins_r[PIN_DACK];
  assign dma_on    = !pins_r[PIN_DACK];
  assign sel_any   = !pins_r[PIN_CS] || dma_on;

  // reset pin filter: only a pulse that lasts the minimum time resets the port
  logic [RST_CNT_W-1:0] rst_cnt_r;
  logic [RST_CNT_W-1:0] rst_cnt_nxt;
  logic                 chip_rst_r;
  logic                 chip_rst_nxt;
  always_comb
  begin
    rst_cnt_nxt = '0;
    if (pins_r[PIN_RST])
    begin
      rst_cnt_nxt = (rst_cnt_r == RST_LIM) ? rst_cnt_r : rst_cnt_r + 8'h01;
    end
    chip_rst_nxt = (rst_cnt_nxt == RST_LIM);
  end
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_cnt_r  <= '0;
      chip_rst_r <= 1'b0;
    end
    else
    begin
      rst_cnt_r  <= rst_cnt_nxt;
      chip_rst_r <= chip_rst_nxt;
    end
  end

  // fifo status seen by the host side
  logic [CW-1:0]     count_r;
  logic              avail_r;
  logic              full;
  logic [DATA_W-1:0] fifo_q;
  assign full = (count_r == CW'(FIFO_DEPTH_P));

  // host cycle tracking; data is latched one cycle after the leading edge so the
  // core sees reg_sel_o before it must answer on reg_rd_data_i
  logic              rd_cyc_r, rd_cyc_nxt;
  logic              rd_lat_r, rd_lat_nxt;
  logic              wr_cyc_r, wr_cyc_nxt;
  logic              oe_r, oe_nxt;
  logic              data_cyc_r, data_cyc_nxt;
  logic [SEL_W-1:0]  sel_r, sel_nxt;
  logic [DATA_W-1:0] bus_q_r, bus_q_nxt;
  logic              reg_wr_r, reg_wr_nxt;
  logic [DATA_W-1:0] reg_wd_r, reg_wd_nxt;
  logic              rd_start;
  logic              wr_start;
  logic              wr_end;
  logic              host_pop;
  logic              host_push;
  always_comb
  begin
    rd_start     = rd_fall && sel_any && !wr_cyc_r;
    wr_start     = wr_fall && sel_any && !rd_cyc_r;
    wr_end       = wr_cyc_r && pins_r[PIN_WR];
    sel_nxt      = (rd_start || wr_start) ? pin_sel : sel_r;
    data_cyc_nxt = (rd_start || wr_start) ? hits_data(dma_on, pin_sel) : data_cyc_r;
    rd_cyc_nxt   = rd_start || (rd_cyc_r && !pins_r[PIN_RD] && sel_any);
    wr_cyc_nxt   = wr_start || (wr_cyc_r && !pins_r[PIN_WR] && sel_any);
    rd_lat_nxt   = rd_start;
    oe_nxt       = rd_cyc_nxt && (rd_lat_r || oe_r);
    host_pop     = rd_lat_r && data_cyc_r && to_host_i && avail_r;
    host_push    = wr_end && data_cyc_r && !to_host_i && !full;
    bus_q_nxt    = bus_q_r;
    if (rd_lat_r)
    begin
      bus_q_nxt = !data_cyc_r ? reg_rd_data_i : (host_pop ? fifo_q : BUS_RESET_VAL);
    end
    reg_wr_nxt = wr_end && !data_cyc_r;
    reg_wd_nxt = wr_end ? pin_data : reg_wd_r;
    if (chip_rst_r)
    begin
      rd_cyc_nxt = 1'b0;
      wr_cyc_nxt = 1'b0;
      rd_lat_nxt = 1'b0;
      oe_nxt     = 1'b0;
      reg_wr_nxt = 1'b0;
      host_pop   = 1'b0;
      host_push  = 1'b0;
    end
  end
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rd_cyc_r   <= 1'b0;
      rd_lat_r   <= 1'b0;
      wr_cyc_r   <= 1'b0;
      oe_r       <= 1'b0;
      data_cyc_r <= 1'b0;
      sel_r      <= '0;
      bus_q_r    <= BUS_RESET_VAL;
      reg_wr_r   <= 1'b0;
      reg_wd_r   <= '0;
    end
    else
    begin
      rd_cyc_r   <= rd_cyc_nxt;
      rd_lat_r   <= rd_lat_nxt;
      wr_cyc_r   <= wr_cyc_nxt;
      oe_r       <= oe_nxt;
      data_cyc_r <= data_cyc_nxt;
      sel_r      <= sel_nxt;
      bus_q_r    <= bus_q_nxt;
      reg_wr_r   <= reg_wr_nxt;
      reg_wd_r   <= reg_wd_nxt;
    end
  end

  // fifo pointers and error flags; direction picks which side fills it
  logic [AW-1:0]     wr_ptr_r, wr_ptr_nxt;
  logic [AW-1:0]     rd_ptr_r, rd_ptr_nxt;
  logic [CW-1:0]     count_nxt;
  logic              avail_nxt;
  logic              ovr_r, ovr_nxt;
  logic              unr_r, unr_nxt;
  logic              dout_v_r, dout_v_nxt;
  logic [DATA_W-1:0] dout_r, dout_nxt;
  logic              push;
  logic              pop;
  logic [DATA_W-1:0] push_data;
  logic              disk_pop;
  always_comb
  begin
    disk_pop   = !to_host_i && disk_out_req_i && avail_r;
    push       = to_host_i ? (disk_in_valid_i && !full) : host_push;
    pop        = to_host_i ? host_pop : disk_pop;
    push_data  = to_host_i ? disk_in_data_i : pin_data;
    wr_ptr_nxt = push ? wr_ptr_r + AW'(1) : wr_ptr_r;
    rd_ptr_nxt = pop ? rd_ptr_r + AW'(1) : rd_ptr_r;
    count_nxt  = count_r + CW'(push) - CW'(pop);
    // a pop hides the head for a cycle while the registered read catches up
    avail_nxt  = (count_r != '0) && !pop;
    // set wins over clear on both flags
    ovr_nxt    = (ovr_r && !flag_clr_i) || (to_host_i && disk_in_valid_i && full);
    unr_nxt    = (unr_r && !flag_clr_i) || (!to_host_i && disk_out_req_i && !avail_r);
    dout_v_nxt = disk_pop;
    dout_nxt   = disk_pop ? fifo_q : dout_r;
    if (chip_rst_r)
    begin
      push       = 1'b0;
      wr_ptr_nxt = '0;
      rd_ptr_nxt = '0;
      count_nxt  = '0;
      avail_nxt  = 1'b0;
      ovr_nxt    = 1'b0;
      unr_nxt    = 1'b0;
      dout_v_nxt = 1'b0;
    end
  end
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      avail_r  <= 1'b0;
      ovr_r    <= 1'b0;
      unr_r    <= 1'b0;
      dout_v_r <= 1'b0;
      dout_r   <= '0;
    end
    else
    begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r  <= count_nxt;
      avail_r  <= avail_nxt;
      ovr_r    <= ovr_nxt;
      unr_r    <= unr_nxt;
      dout_v_r <= dout_v_nxt;
      dout_r   <= dout_nxt;
    end
  end

  fdc_fifo_mem #(
    .W     (DATA_W),
    .DEPTH (FIFO_DEPTH_P),
    .AW    (AW)
  ) u_mem (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .we_i       (push),
    .waddr_i    (wr_ptr_r),
    .wdata_i    (push_data),
    .raddr_i    (rd_ptr_nxt),
    .rdata_o    (fifo_q)
  );

  // dma request sequencer; hold waits for the grant to rise before asking again
  drq_state_e st_r, st_nxt;
  logic       need;
  logic       tc_ok;
  logic       release_now;
  logic       byte_taken;
  logic       drq_r, drq_nxt;
  logic       tc_r, tc_nxt;
  logic       irq_r;
  always_comb
  begin
    need        = xfer_active_i && dma_enable_i && (to_host_i ? avail_r : !full);
    tc_ok       = pins_r[PIN_TC] && dma_on;
    tc_nxt      = tc_ok && !(prev_r[PIN_TC] && !prev_r[PIN_DACK]) && !chip_rst_r;
    release_now = last_byte_i || non_burst_i || tc_ok;
    // grant falling ends the byte, or a strobe if grant was already low
    byte_taken  = dack_fall || (dma_on && (rd_fall || wr_fall));
    st_nxt      = st_r;
    case (st_r)
      DRQ_IDLE:
      begin
        if (need)
        begin
          st_nxt = DRQ_ASK;
        end
      end
      DRQ_ASK:
      begin
        if (byte_taken && release_now)
        begin
          st_nxt = DRQ_HOLD;
        end
        else if (!need && !dma_on)
        begin
          st_nxt = DRQ_IDLE;
        end
      end
      DRQ_HOLD:
      begin
        if (!dma_on)
        begin
          st_nxt = DRQ_IDLE;
        end
      end
      default:
      begin
        st_nxt = DRQ_IDLE;
      end
    endcase
    if (chip_rst_r)
    begin
      st_nxt = DRQ_IDLE;
    end
    drq_nxt = (st_nxt == DRQ_ASK);
  end
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_r  <= DRQ_IDLE;
      drq_r <= 1'b0;
      tc_r  <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      st_r  <= st_nxt;
      drq_r <= drq_nxt;
      tc_r  <= tc_nxt;
      irq_r <= irq_pending_i;
    end
  end

  // outputs straight from flip-flops
  assign host_data_bus_o    = bus_q_r;
  assign host_data_bus_oe_o = oe_r;
  assign dma_request_o      = drq_r;
  assign irq_o              = irq_r;
  assign disk_out_data_o    = dout_r;
  assign disk_out_valid_o   = dout_v_r;
  assign overrun_o          = ovr_r;
  assign underrun_o         = unr_r;
  assign tc_seen_o          = tc_r;
  assign chip_reset_o       = chip_rst_r;
  assign reg_sel_o          = sel_r;
  assign reg_wr_o           = reg_wr_r;
  assign reg_wr_data_o      = reg_wd_r;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  a_bus_read_only: assert property (oe_r |-> $past(!pins_r[PIN_RD] && sel_any))
    else $error("data bus driven outside a read");
  a_sel_capture: assert property ((rd_start || wr_start) && !chip_rst_r |=> sel_r == $past(pin_sel))
    else $error("register select not captured at strobe edge");
  a_drq_cause: assert property ($rose(dma_request_o) |-> $past(need))
    else $error("dma request without need");
  a_drq_last_grant: assert property (st_r == DRQ_ASK && dack_fall && last_byte_i |=> !dma_request_o)
    else $error("request held after last byte grant");
  a_drq_demand: assert property (st_r == DRQ_ASK && dma_on && rd_fall && last_byte_i |=> !dma_request_o)
    else $error("request held after demand mode last read");
  a_dma_path: assert property (rd_start && dma_on && !chip_rst_r |=> data_cyc_r)
    else $error("granted cycle missed data path");
  a_tc_gated: assert property (tc_seen_o |-> $past(dma_on))
    else $error("terminal count taken without grant");
  a_irq_follow: assert property (##1 irq_o == $past(irq_pending_i))
    else $error("interrupt output not following core");
  a_idle_ignore: assert property (!sel_any |=> !host_data_bus_oe_o)
    else $error("bus driven while unselected");
  a_fifo_bound: assert property (count_r <= CW'(FIFO_DEPTH_P))
    else $error("fifo count beyond depth");
  a_nonburst_gap: assert property (st_r == DRQ_ASK && dack_fall && non_burst_i |=> !dma_request_o [*2])
    else $error("non-burst request not released");
  a_overrun_set: assert property (to_host_i && disk_in_valid_i && full && !chip_rst_r |=> overrun_o)
    else $error("overrun not flagged");
  a_reset_clear: assert property ($rose(chip_rst_r) |-> $past(pins_r[PIN_RST], 2) ##1 count_r == '0 && !overrun_o)
    else $error("internal reset incomplete");

  c_dma_read: cover property (rd_start && dma_on && to_host_i);
  c_reg_write: cover property (reg_wr_o);
  c_nonburst: cover property (st_r == DRQ_ASK && dack_fall && non_burst_i);
  c_overrun: cover property ($rose(overrun_o));

endmodule : floppy_host_bus_port

// ==== hdl/fdc_port_pkg.sv ====
// shared constants of the floppy controller host bus port
// assumes a single 250 MHz core clock; all pin inputs are sampled in that domain
package fdc_port_pkg;

  localparam int DATA_W     = 8;
  localparam int SEL_W      = 3;
  localparam int FIFO_DEPTH = 16;

  // register select value that reaches the data fifo outside dma cycles
  localparam logic [SEL_W-1:0] DATA_REG_SEL = 3'h5;

  // layout of the synchronised pin vector
  localparam int PIN_DATA_LSB = 0;
  localparam int PIN_SEL_LSB  = 8;
  localparam int PIN_RD       = 11;
  localparam int PIN_WR       = 12;
  localparam int PIN_CS       = 13;
  localparam int PIN_DACK     = 14;
  localparam int PIN_TC       = 15;
  localparam int PIN_RST      = 16;
  localparam int PIN_W        = 17;

  // chip reset pin must stay high this long before it takes effect
  localparam int RESET_MIN_NS  = 500;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RST_CNT_W     = 8;

  localparam logic [DATA_W-1:0] BUS_RESET_VAL = 8'h00;

  // dma request sequencer, gray coded along idle -> ask -> hold
  typedef enum logic [1:0]
  {
    DRQ_IDLE = 2'b00,
    DRQ_ASK  = 2'b01,
    DRQ_HOLD = 2'b11
  } drq_state_e;

endpackage : fdc_port_pkg

// ==== tb/floppy_host_bus_port_bench.sv ====
// self-checking bench of the floppy host bus port against a host and dma model
// assumes the model's cycle task is only used while its dma engine is idle
`timescale 1ns/1ps
`define CHK(w, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %s expected %h seen %h", w, e, g); end end
module floppy_host_bus_port_bench;
  import fdc_port_pkg::*;
  logic core_clk_i = 1'b0, nrst_i = 1'b0, reset_i = 1'b0, irq_pending_i = 1'b0, flag_clr = 1'b0;
  logic to_host_i = 1'b0, xfer_active_i = 1'b0, dma_enable_i = 1'b0, non_burst_i = 1'b0;
  logic last_byte_i = 1'b0, disk_in_valid_i = 1'b0, disk_out_req_i = 1'b0;
  logic dma_on = 1'b0, slow = 1'b0, tc_en = 1'b0, demand = 1'b0, cr_seen = 1'b0, drq_q, s;
  logic [DATA_W-1:0] disk_in_data_i = '0, reg_rd_data_i = '0, host_data_bus_i, drv;
  logic [DATA_W-1:0] host_data_bus_o, disk_out_data_o, reg_wr_data_o, wr_last, b, d;
  logic [SEL_W-1:0]  register_select_i, reg_sel_o, wr_sel, sel;
  logic host_data_bus_oe_o, host_read_strobe_n_i, host_write_strobe_n_i, chip_select_n_i;
  logic dma_grant_n_i, terminal_count_i, dma_request_o, irq_o, disk_out_valid_o;
  logic overrun_o, underrun_o, tc_seen_o, chip_reset_o, reg_wr_o;
  logic [DATA_W-1:0] exp_q[$];
  int bad_count = 0, compares = 0, wr_cnt = 0, rises = 0, tc_cnt = 0, k, m, n0;

  always #2 core_clk_i = ~core_clk_i;
  // the data pins carry the device only while it drives them
  assign host_data_bus_i = host_data_bus_oe_o ? host_data_bus_o : drv;

  floppy_host_bus_port uut (.core_clk_i, .nrst_i, .host_data_bus_i, .host_data_bus_o,
    .host_data_bus_oe_o, .host_read_strobe_n_i, .host_write_strobe_n_i, .register_select_i,
    .chip_select_n_i, .dma_grant_n_i, .terminal_count_i, .reset_i, .dma_request_o, .irq_o,
    .irq_pending_i, .to_host_i, .xfer_active_i, .dma_enable_i, .non_burst_i, .last_byte_i,
    .disk_in_valid_i, .disk_in_data_i, .disk_out_req_i, .disk_out_data_o, .disk_out_valid_o,
    .flag_clr_i(flag_clr), .overrun_o, .underrun_o, .tc_seen_o, .chip_reset_o, .reg_rd_data_i,
    .reg_sel_o, .reg_wr_o, .reg_wr_data_o);

  host_side_model hm (.core_clk_i, .dma_on_i(dma_on), .slow_i(slow), .tc_en_i(tc_en),
    .drq_i(dma_request_o), .oe_i(host_data_bus_oe_o), .bus_i(host_data_bus_i),
    .rd_n_o(host_read_strobe_n_i), .wr_n_o(host_write_strobe_n_i),
    .cs_n_o(chip_select_n_i), .grant_n_o(dma_grant_n_i), .tc_o(terminal_count_i),
    .sel_o(register_select_i), .drv_o(drv), .demand_i(demand));

  // event counters; pulses are too short to poll from the sequence
  always @(posedge core_clk_i)
  begin
    drq_q <= dma_request_o;
    if (dma_request_o === 1'b1 && drq_q === 1'b0) rises++;
    if (tc_seen_o === 1'b1) tc_cnt++;
    if (chip_reset_o === 1'b1) cr_seen = 1'b1;
    if (reg_wr_o === 1'b1)
    begin
      wr_cnt++;
      wr_last = reg_wr_data_o;
      wr_sel = reg_sel_o;
    end
  end

  task automatic push(input logic [DATA_W-1:0] v);
    @(negedge core_clk_i);
    disk_in_valid_i = 1'b1;
    disk_in_data_i = v;
    @(negedge core_clk_i);
    disk_in_valid_i = 1'b0;
  endtask : push

  // disk side asks for one byte; requests are spaced so the fifo head is visible
  task automatic pull(output logic [DATA_W-1:0] v, output logic ok);
    int i;
    ok = 1'b0;
    v = '0;
    @(negedge core_clk_i);
    disk_out_req_i = 1'b1;
    for (i = 0; i < 4; i++)
    begin
      @(negedge core_clk_i);
      disk_out_req_i = 1'b0;
      if (disk_out_valid_o === 1'b1) v = disk_out_data_o;
      if (disk_out_valid_o === 1'b1) ok = 1'b1;
    end
  endtask : pull

  task automatic results;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  // watchdog: the sequence needs well under 20000 clocks
  initial
  begin
    #120000;
    bad_count++;
    results();
  end

  initial
  begin
    void'($urandom(32'hc50e));
    repeat (4) @(negedge core_clk_i);
    `CHK("oe in reset", 1'b0, host_data_bus_oe_o)
    `CHK("drq in reset", 1'b0, dma_request_o)
    nrst_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    // interrupt output follows the pending condition one clock later
    for (k = 0; k < 20; k++)
    begin
      b = 8'($urandom);
      irq_pending_i = b[0];
      @(negedge core_clk_i);
      `CHK("irq", b[0], irq_o)
    end
    // register writes and reads at random selects other than the fifo
    for (k = 0; k < 8; k++)
    begin
      sel = 3'($urandom_range(6, 0));
      if (sel >= DATA_REG_SEL) sel++;
      b = 8'($urandom);
      reg_rd_data_i = 8'($urandom);
      n0 = wr_cnt;
      hm.strobe(1'b0, 1'b0, sel, b, d, s);
      `CHK("write count", n0 + 1, wr_cnt)
      `CHK("write data", b, wr_last)
      `CHK("write select", sel, wr_sel)
      hm.strobe(1'b1, 1'b0, sel, 8'h00, d, s);
      `CHK("read answered", 1'b1, s)
      `CHK("read data", reg_rd_data_i, d)
      `CHK("read select", sel, reg_sel_o)
      `CHK("bus released", 1'b0, host_data_bus_oe_o)
    end
    // strobes without chip select or grant are ignored
    n0 = wr_cnt;
    hm.strobe(1'b1, 1'b1, 3'h1, 8'h00, d, s);
    `CHK("read refused", 1'b0, s)
    hm.strobe(1'b0, 1'b1, 3'h1, 8'h3c, d, s);
    `CHK("write refused", n0, wr_cnt)
    // host to disk: fill past sixteen, drain, then one request too many
    for (k = 0; k < 17; k++)
    begin
      b = 8'($urandom);
      if (k < 16) exp_q.push_back(b);
      hm.strobe(1'b0, 1'b0, DATA_REG_SEL, b, d, s);
    end
    `CHK("fifo writes", n0, wr_cnt)
    for (k = 0; k < 17; k++)
    begin
      d = (k < 16) ? exp_q.pop_front() : 8'h00;
      if (k == 16) `CHK("underrun early", 1'b0, underrun_o)
      pull(b, s);
      `CHK("disk valid", k < 16, s)
      if (k < 16) `CHK("disk data", d, b)
    end
    `CHK("underrun", 1'b1, underrun_o)
    // disk to host by dma: non-burst, burst with last byte, burst with count, demand
    to_host_i = 1'b1;
    for (m = 0; m < 4; m++)
    begin
      non_burst_i = (m == 0);
      last_byte_i = (m == 1);
      slow = (m == 1);
      tc_en = (m == 2);
      demand = (m == 3);
      for (k = 0; k < 4; k++)
      begin
        b = 8'($urandom);
        exp_q.push_back(b);
        push(b);
      end
      rises = 0;
      tc_cnt = 0;
      hm.got.delete();
      xfer_active_i = 1'b1;
      dma_enable_i = 1'b1;
      dma_on = 1'b1;
      for (k = 0; k < 3000 && hm.got.size() < 4; k++)
      begin
        @(negedge core_clk_i);
        // demand mode: the final byte is flagged before its read strobe falls
        if (m == 3) last_byte_i = (hm.got.size() == 3);
      end
      if (m == 3) `CHK("demand drop", 1'b0, dma_request_o)
      dma_on = 1'b0;
      repeat (10) @(negedge core_clk_i);
      xfer_active_i = 1'b0;
      dma_enable_i = 1'b0;
      `CHK("dma bytes", 4, hm.got.size())
      for (k = 0; k < 4; k++)
      begin
        b = exp_q.pop_front();
        d = (hm.got.size() > 0) ? hm.got.pop_front() : 8'hxx;
        `CHK("dma data", b, d)
      end
      if (m != 2) `CHK("drq asks", (m == 3) ? 1 : 4, rises)
      `CHK("tc taken", (m == 2) ? 4 : 0, tc_cnt)
    end
    tc_cnt = 0;
    hm.tc_pulse();
    repeat (6) @(negedge core_clk_i);
    `CHK("tc without grant", 0, tc_cnt)
    // overrun only on the push after sixteen
    for (k = 0; k < 17; k++)
    begin
      if (k == 16) `CHK("overrun early", 1'b0, overrun_o)
      push(8'($urandom));
    end
    // a clear in the cycle of a new overrun loses, a clear alone wins
    @(negedge core_clk_i);
    flag_clr = 1'b1;
    disk_in_valid_i = 1'b1;
    @(negedge core_clk_i);
    disk_in_valid_i = 1'b0;
    `CHK("set beats clear", 1'b1, overrun_o)
    @(negedge core_clk_i);
    flag_clr = 1'b0;
    `CHK("flag cleared", 1'b0, overrun_o)
    push(8'h00);
    repeat (3) @(negedge core_clk_i);
    `CHK("overrun", 1'b1, overrun_o)
    // a short reset pulse is ignored, a long one clears flags and fifo
    reset_i = 1'b1;
    repeat (50) @(negedge core_clk_i);
    reset_i = 1'b0;
    repeat (10) @(negedge core_clk_i);
    `CHK("short reset", 1'b0, cr_seen)
    `CHK("flag kept", 1'b1, overrun_o)
    reset_i = 1'b1;
    repeat (140) @(negedge core_clk_i);
    `CHK("chip reset", 1'b1, chip_reset_o)
    reset_i = 1'b0;
    repeat (10) @(negedge core_clk_i);
    `CHK("overrun cleared", 1'b0, overrun_o)
    `CHK("underrun cleared", 1'b0, underrun_o)
    hm.strobe(1'b1, 1'b0, DATA_REG_SEL, 8'h00, d, s);
    `CHK("fifo emptied", 8'h00, d)
    results();
  end
endmodule : floppy_host_bus_port_bench

// ==== tb/host_side_model.sv ====
// host processor and dma controller model driving the host pins of the port
// assumes the bench muxes the data pins from the device's output enable
`timescale 1ns/1ps
module host_side_model (
  input  wire logic                            core_clk_i,
  input  wire logic                            dma_on_i,
  input  wire logic                            slow_i,
  input  wire logic                            tc_en_i,
  input  wire logic                            demand_i,
  input  wire logic                            drq_i,
  input  wire logic                            oe_i,
  input  wire logic [fdc_port_pkg::DATA_W-1:0] bus_i,
  output logic                                 rd_n_o,
  output logic                                 wr_n_o,
  output logic                                 cs_n_o,
  output logic                                 grant_n_o,
  output logic                                 tc_o,
  output logic      [fdc_port_pkg::SEL_W-1:0]  sel_o,
  output logic      [fdc_port_pkg::DATA_W-1:0] drv_o
);
  import fdc_port_pkg::*;
  logic [DATA_W-1:0] got[$];
  logic [DATA_W-1:0] d;
  logic              s;

  // idle pins: strobes, select and grant released
  initial
  begin
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    cs_n_o = 1'b1;
    grant_n_o = 1'b1;
    tc_o = 1'b0;
    sel_o = '0;
    drv_o = 8'h5a;
  end

  // one strobed cycle; select is spoiled before release to prove the early capture
  task automatic strobe(input logic rd, input logic cs_n, input logic [SEL_W-1:0] sel,
                        input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rdata,
                        output logic seen);
    int i;
    seen = 1'b0;
    @(negedge core_clk_i);
    cs_n_o = cs_n;
    sel_o = sel;
    drv_o = wd;
    rd_n_o = ~rd;
    wr_n_o = rd;
    // hold the request until the bus is driven or the wait runs out
    for (i = 0; i < 10 && !seen; i++)
    begin
      @(negedge core_clk_i);
      if (oe_i === 1'b1) seen = 1'b1;
    end
    rdata = bus_i;
    sel_o = ~sel;
    @(negedge core_clk_i);
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    repeat (5) @(negedge core_clk_i);
    cs_n_o = 1'b1;
    drv_o = ~wd; // released bus shows the inverse, not the last value
  endtask : strobe

  // terminal count raised with no grant; the device must not take it
  task automatic tc_pulse;
    @(negedge core_clk_i);
    tc_o = 1'b1;
    repeat (3) @(negedge core_clk_i);
    tc_o = 1'b0;
  endtask : tc_pulse

  // dma engine: grants each request by a read cycle, promptly or slowly; in demand
  // mode the grant stays low across bytes until the engine is switched off
  always
  begin
    @(negedge core_clk_i);
    if (dma_on_i !== 1'b1)
    begin
      grant_n_o = 1'b1;
    end
    else if (drq_i === 1'b1)
    begin
      if (slow_i) repeat (6) @(negedge core_clk_i);
      grant_n_o = 1'b0;
      tc_o = tc_en_i;
      strobe(1'b1, 1'b1, '0, 8'h00, d, s);
      got.push_back(d);
      grant_n_o = !demand_i;
      tc_o = 1'b0;
      repeat (3) @(negedge core_clk_i);
    end
  end
endmodule : host_side_model
